/* File: src/burst_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module burst_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = sram_link_pkg::FIFO_DEPTH
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   import sram_link_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  store [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic          in_ready_r;
   logic          push;
   logic          pop;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // Ready is registered so a full FIFO refuses the very next push.
   assign push      = in_valid && in_ready_r;
   assign pop       = out_valid && out_ready;
   assign out_valid = (count_r != '0);
   assign out_data  = store[rd_ptr_r];
   assign in_ready  = in_ready_r;

   // Occupancy after this edge.
   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = CW'(count_r + 1'b1);
      end else if (pop && !push) begin
         count_nxt = CW'(count_r - 1'b1);
      end
   end

   // Pointers, count and registered ready.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr_r   <= '0;
         rd_ptr_r   <= '0;
         count_r    <= '0;
         in_ready_r <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= next_ptr(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= next_ptr(rd_ptr_r);
         end
         count_r    <= count_nxt;
         in_ready_r <= (count_nxt < CW'(DEPTH));
      end
   end

   // Storage has no reset; only entries below the count are ever read.
   always_ff @(posedge core_clk) begin
      if (push) begin
         store[wr_ptr_r] <= in_data;
      end
   end
endmodule

/* File: src/sram_ctrl_end.sv */
// Controller end: drives the link from a burst FIFO and a read request port.
`timescale 1ns/1ns
module sram_ctrl_end #(
   parameter int DW    = sram_link_pkg::DW_X36,
   parameter int AW    = sram_link_pkg::addr_w_f(DW),
   parameter int LN    = sram_link_pkg::lanes_f(DW),
   parameter int DEPTH = sram_link_pkg::FIFO_DEPTH
) (
   input  wire logic                                   core_clk,
   input  wire logic                                   rst,
   sram_link_if.ctrl                                   link,
   input  wire logic                                   wr_valid,
   output logic                                        wr_ready,
   input  wire logic [AW-1:0]                          wr_addr,
   input  wire logic [sram_link_pkg::BURST_LEN*LN-1:0] wr_lane_sel_n,
   input  wire logic [sram_link_pkg::BURST_LEN*DW-1:0] wr_data,
   input  wire logic                                   rd_req_valid,
   output logic                                        rd_req_ready,
   input  wire logic [AW-1:0]                          rd_req_addr,
   output logic [DW-1:0]                               rd_data,
   output logic                                        rd_data_valid
);
   import sram_link_pkg::*;

   localparam int FW = AW + BURST_LEN * (LN + DW);

   logic [1:0]    slot_r;
   logic [1:0]    slot_nxt;
   logic [1:0]    beat_nxt;
   logic          k_true_r;
   logic          wps_n_r;
   logic          rps_n_r;
   logic [AW-1:0] addr_r;
   logic [DW-1:0] d_r;
   logic [LN-1:0] sel_n_r;
   logic [FW-1:0] hold_r;
   logic [2:0]    wr_left_r;
   logic          rd_ready_r;
   logic [DW-1:0] rd_data_r;
   logic          rd_valid_r;
   logic          fifo_valid;
   logic [FW-1:0] fifo_data;
   logic          wr_start;
   logic          rd_start;

   // Whole bursts queue here; the link drains one per four cycles.
   burst_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   ({wr_addr, wr_lane_sel_n, wr_data}),
      .out_valid (fifo_valid),
      .out_ready (wr_start),
      .out_data  (fifo_data)
   );

   // Read address goes out on one true edge, write address on the other.
   assign slot_nxt = slot_r + 2'h1;
   assign beat_nxt = slot_nxt + 2'h1;
   assign wr_start = (slot_nxt == SLOT_WRITE) && fifo_valid;
   assign rd_start = rd_req_valid && rd_ready_r;

   // Clock phase: each cycle is one edge, true and complement alternating.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slot_r     <= SLOT_RESET;
         k_true_r   <= 1'b0;
         rd_ready_r <= 1'b0;
      end else begin
         slot_r     <= slot_nxt;
         k_true_r   <= ~slot_nxt[0];
         rd_ready_r <= (slot_nxt == SLOT_BEFORE_READ);
      end
   end

   // Shared address bus, loaded only with the select it belongs to.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_r  <= '0;
         rps_n_r <= 1'b1;
      end else begin
         rps_n_r <= ~rd_start;
         if (rd_start) begin
            addr_r <= rd_req_addr;
         end else if (wr_start) begin
            addr_r <= fifo_data[FW-1 -: AW];
         end
      end
   end

   // Write burst: command on a true edge, then four beats on the next four edges.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wps_n_r   <= 1'b1;
         wr_left_r <= '0;
         d_r       <= '0;
         sel_n_r   <= '1;
         hold_r    <= '0;
      end else begin
         wps_n_r <= ~wr_start;
         if (wr_left_r != '0) begin
            d_r       <= hold_r[beat_nxt*DW +: DW];
            sel_n_r   <= hold_r[BURST_LEN*DW + beat_nxt*LN +: LN];
            wr_left_r <= wr_left_r - 3'h1;
         end else begin
            sel_n_r <= '1;
         end
         if (wr_start) begin
            hold_r    <= fifo_data;
            wr_left_r <= BURST_CNT;
         end
      end
   end

   // Read data is taken whenever the memory drives its outputs.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_data_r  <= '0;
         rd_valid_r <= 1'b0;
      end else begin
         rd_data_r  <= link.q;
         rd_valid_r <= ~link.q_oe_n;
      end
   end

   assign link.k_true                   = k_true_r;
   assign link.write_port_select_n      = wps_n_r;
   assign link.read_port_select_n       = rps_n_r;
   assign link.byte_lane_write_select_n = sel_n_r;
   assign link.addr                     = addr_r;
   assign link.d                        = d_r;
   assign rd_req_ready                  = rd_ready_r;
   assign rd_data                       = rd_data_r;
   assign rd_data_valid                 = rd_valid_r;
endmodule

/* File: src/sram_link_if.sv */
// Link between the memory controller end and the SRAM end.
`timescale 1ns/1ns
interface sram_link_if #(
   parameter int DW = sram_link_pkg::DW_X36,
   parameter int AW = sram_link_pkg::addr_w_f(DW),
   parameter int LN = sram_link_pkg::lanes_f(DW)
);
   logic          k_true;
   logic          write_port_select_n;
   logic          read_port_select_n;
   logic [LN-1:0] byte_lane_write_select_n;
   logic [AW-1:0] addr;
   logic [DW-1:0] d;
   logic [DW-1:0] q;
   logic          q_oe_n;

   // The controller drives clock phase, selects, address and write data.
   modport ctrl (
      output k_true,
      output write_port_select_n,
      output read_port_select_n,
      output byte_lane_write_select_n,
      output addr,
      output d,
      input  q,
      input  q_oe_n
   );

   // The memory samples everything and drives the read data back.
   modport mem (
      input  k_true,
      input  write_port_select_n,
      input  read_port_select_n,
      input  byte_lane_write_select_n,
      input  addr,
      input  d,
      output q,
      output q_oe_n
   );
endinterface

/* File: src/sram_link_pkg.sv */
// Shared constants and width functions for both ends of the dual rate SRAM link.
package sram_link_pkg;
   // Data widths of the three organizations and their address widths.
   localparam int DW_X8  = 8;
   localparam int DW_X18 = 18;
   localparam int DW_X36 = 36;
   localparam int AW_X8  = 19;
   localparam int AW_X18 = 18;
   localparam int AW_X36 = 17;
   // Byte lane layout: x8 uses two 4-bit lanes, the others 9-bit lanes.
   localparam int LANE_W_X8    = 4;
   localparam int LANE_W_WIDE  = 9;
   localparam int LANES_NARROW = 2;
   localparam int LANES_X36    = 4;
   // Burst of four beats, one word from each of the four internal arrays.
   localparam int BURST_LEN = 4;
   localparam int BEAT_W    = 2;
   localparam logic [2:0] BURST_CNT = 3'h4;
   // Link cycle slots: true clock edges fall on slots 0 and 2.
   localparam logic [1:0] SLOT_READ        = 2'h0;
   localparam logic [1:0] SLOT_WRITE       = 2'h2;
   localparam logic [1:0] SLOT_BEFORE_READ = 2'h3;
   localparam logic [1:0] SLOT_RESET       = 2'h3;
   localparam int FIFO_DEPTH = 16;

   function automatic int addr_w_f(input int dw);
      return (dw == DW_X8) ? AW_X8 : ((dw == DW_X18) ? AW_X18 : AW_X36);
   endfunction

   function automatic int lanes_f(input int dw);
      return (dw == DW_X36) ? LANES_X36 : LANES_NARROW;
   endfunction

   function automatic int lane_w_f(input int dw);
      return (dw == DW_X8) ? LANE_W_X8 : LANE_W_WIDE;
   endfunction
endpackage

/* File: src/sram_mem_end.sv */
// Memory end: write capture with lane masks, address latch and read bursts.
`timescale 1ns/1ns
module sram_mem_end #(
   parameter int DW       = sram_link_pkg::DW_X36,
   parameter int AW       = sram_link_pkg::addr_w_f(DW),
   parameter int LN       = sram_link_pkg::lanes_f(DW),
   parameter int STORE_AW = AW
) (
   input  wire logic core_clk,
   input  wire logic rst,
   sram_link_if.mem  link,
   output logic      write_active,
   output logic      read_active,
   output logic      select_dropped
);
   import sram_link_pkg::*;

   // Lane width and storage geometry of this organization.
   localparam int LW    = lane_w_f(DW);
   localparam int IW    = STORE_AW + BEAT_W;
   localparam int DEPTH = BURST_LEN << STORE_AW;
   // A store narrower than the address drops the upper address bits, so
   // distinct addresses alias; shrink it only where traffic stays apart.

   // Four arrays folded into one: the low index bits pick the array.
   logic [DW-1:0]       store [0:DEPTH-1];

   // Write side.
   logic [2:0]          wr_left_r;
   logic [BEAT_W-1:0]   wr_beat_r;
   logic [AW-1:0]       wr_base_r;
   logic                wr_take;
   logic                wr_en;
   logic [IW-1:0]       wr_idx;
   logic [DW-1:0]       wr_mask;
   logic [DW-1:0]       wr_word;
   logic                wr_dropped;

   // Read side.
   logic [2:0]          rd_left_r;
   logic [BEAT_W-1:0]   rd_beat_r;
   logic [AW-1:0]       rd_base_r;
   logic                rd_take;
   logic                rd_en;
   logic [IW-1:0]       rd_idx;
   logic [DW-1:0]       q_r;
   logic                q_oe_n_r;
   logic                rd_dropped;
   logic                fwd_hit;

   // Status.
   logic                write_active_r;
   logic                read_active_r;
   logic                dropped_r;

   // Expands the active-low lane selects into a per-bit write mask.
   function automatic logic [DW-1:0] lane_mask(input logic [LN-1:0] sel_n);
      logic [DW-1:0] m;
      m = '0;
      for (int b = 0; b < DW; b++) begin
         m[b] = ~sel_n[b / LW];
      end
      return m;
   endfunction

   // Replaces only the bits under the mask.
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                           input logic [DW-1:0] new_w,
                                           input logic [DW-1:0] mask);
      return (old_w & ~mask) | (new_w & mask);
   endfunction

   // Array index of one beat: stored address bits above, beat number below.
   function automatic logic [IW-1:0] burst_idx(input logic [AW-1:0]     base,
                                               input logic [BEAT_W-1:0] beat);
      return {base[STORE_AW-1:0], beat};
   endfunction

   // A port may open a new burst when idle or on the last beat of the old one.
   function automatic logic burst_free(input logic [2:0] left);
      return (left <= 3'h1);
   endfunction

   // Beats still owed after this edge by a burst that is not reopened.
   function automatic logic beats_owed(input logic [2:0] left);
      return (left > 3'h1);
   endfunction

   // Commands are only taken on a true edge. A burst may be chained from
   // its last beat, but a select that lands mid-burst is dropped rather
   // than corrupting the burst in flight.
   assign wr_take = link.k_true && !link.write_port_select_n
                    && burst_free(wr_left_r);
   assign rd_take = link.k_true && !link.read_port_select_n
                    && burst_free(rd_left_r);

   // A select on a true edge that its port cannot take is lost, not queued.
   assign wr_dropped = link.k_true && !link.write_port_select_n && !wr_take;
   assign rd_dropped = link.k_true && !link.read_port_select_n && !rd_take;

   // Current beat positions inside the four arrays.
   assign wr_en   = (wr_left_r != '0);
   assign rd_en   = (rd_left_r != '0);
   assign wr_idx  = burst_idx(wr_base_r, wr_beat_r);
   assign rd_idx  = burst_idx(rd_base_r, rd_beat_r);

   // Lane selects are read in the same cycle as the data they qualify.
   assign wr_mask = lane_mask(link.byte_lane_write_select_n);
   assign wr_word = merge(store[wr_idx], link.d, wr_mask);

   // A read of the word written on the same edge must see the new value.
   assign fwd_hit = wr_en && (wr_idx == rd_idx);

   // Write address latch and beat counter.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_left_r <= '0;
         wr_beat_r <= '0;
         wr_base_r <= '0;
      end else if (wr_take) begin
         // Address only moves while the write port is selected.
         wr_base_r <= link.addr;
         wr_left_r <= BURST_CNT;
         wr_beat_r <= '0;
      end else if (wr_en) begin
         wr_left_r <= wr_left_r - 3'h1;
         wr_beat_r <= wr_beat_r + 2'h1;
      end
   end

   // Array update: one beat per edge, true or complement alike. Without an
   // open burst the data pins are not looked at and nothing changes.
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         store[wr_idx] <= wr_word;
      end
   end

   // Read address latch and beat counter.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_left_r <= '0;
         rd_beat_r <= '0;
         rd_base_r <= '0;
      end else if (rd_take) begin
         rd_base_r <= link.addr;
         rd_left_r <= BURST_CNT;
         rd_beat_r <= '0;
      end else if (rd_en) begin
         rd_left_r <= rd_left_r - 3'h1;
         rd_beat_r <= rd_beat_r + 2'h1;
      end
   end

   // Read output register. A word being written on the same edge is
   // forwarded, so a read always returns the most recent data.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         q_r      <= '0;
         q_oe_n_r <= 1'b1;
      end else if (rd_en) begin
         if (fwd_hit) begin
            q_r <= wr_word;
         end else begin
            q_r <= store[rd_idx];
         end
         q_oe_n_r <= 1'b0;
      end else begin
         // The pending burst has ended; release the outputs.
         q_oe_n_r <= 1'b1;
      end
   end

   // Status outputs: a port is active while a burst is open after this edge.
   // A select dropped because a burst was still open is flagged for a cycle.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         write_active_r <= 1'b0;
         read_active_r  <= 1'b0;
         dropped_r      <= 1'b0;
      end else begin
         write_active_r <= wr_take || beats_owed(wr_left_r);
         read_active_r  <= rd_take || beats_owed(rd_left_r);
         dropped_r      <= wr_dropped || rd_dropped;
      end
   end

   // Every output leaves from a flip-flop.
   assign link.q         = q_r;
   assign link.q_oe_n    = q_oe_n_r;
   assign write_active   = write_active_r;
   assign read_active    = read_active_r;
   assign select_dropped = dropped_r;
endmodule

/* File: testbench/sram_link_monitor.sv */
// Concurrent checks on the link between the controller end and the SRAM end.
`timescale 1ns/1ns
module sram_link_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic k_true,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic q_oe_n
);
   import sram_link_pkg::*;
   // All checks sample on the core clock and stand down while reset is high.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // The edge flag must flip every cycle, or beats land on the wrong input clock.
   k_alternate_a: assert property (!$past(rst) |-> k_true != $past(k_true))
      else $error("true and complement edges did not alternate");
   write_on_true_a: assert property (!write_port_select_n |-> k_true)
      else $error("write select low on a complement edge");
   read_on_true_a: assert property (!read_port_select_n |-> k_true)
      else $error("read select low on a complement edge");
   // A write command owns the next four beats, so no second one before its last beat.
   write_spacing_a: assert property (
      !write_port_select_n |-> ##1 write_port_select_n [*3])
      else $error("write commands closer than four cycles");
   ports_alternate_a: assert property (
      !read_port_select_n |-> write_port_select_n ##2 read_port_select_n)
      else $error("read and write addresses share a true edge");
   read_window_a: assert property (!read_port_select_n |-> ##2 !q_oe_n [*4])
      else $error("read data not driven for four beats");
   // Once a lone burst finishes the outputs must float again.
   read_float_a: assert property (
      !read_port_select_n ##4 read_port_select_n |-> ##2 q_oe_n)
      else $error("read outputs still driven after the burst");
   oe_cause_a: assert property (
      $fell(q_oe_n) |-> $past(read_port_select_n, 2) == 1'b0)
      else $error("read outputs driven without a read command");
endmodule

/* File: testbench/tb_dual_rate_sram_write_addr_port.sv */
// Self-checking bench joining the controller end to the SRAM end across the link.
`timescale 1ns/1ns
module tb_dual_rate_sram_write_addr_port;
   import sram_link_pkg::*;
   localparam int DW = DW_X36;
   localparam int AW = addr_w_f(DW);
   localparam int LN = lanes_f(DW);
   localparam int LW = lane_w_f(DW);
   localparam int MW = BURST_LEN * LN;
   logic            core_clk, rst, wr_valid, wr_ready, rd_req_valid, rd_req_ready;
   logic            rd_data_valid, write_active, read_active, select_dropped;
   logic [AW-1:0]   wr_addr, rd_req_addr;
   logic [MW-1:0]   wr_lane_sel_n;
   logic [4*DW-1:0] wr_data;
   logic [DW-1:0]   rd_data;
   logic [DW-1:0]   ref_mem [16][4];
   logic [DW-1:0]   exp_q [$];
   logic [MW-1:0]   corner [4];
   int              seed, failures, checks, i;

   // Clock at 20 MHz.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   sram_link_if #(.DW(DW)) link ();
   sram_ctrl_end #(.DW(DW)) sram_ctrl_end_inst (.core_clk(core_clk), .rst(rst), .link(link),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
      .wr_lane_sel_n(wr_lane_sel_n), .wr_data(wr_data), .rd_req_valid(rd_req_valid),
      .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr), .rd_data(rd_data),
      .rd_data_valid(rd_data_valid));
   // Four stored address bits keep the run short; the bench stays inside 0 to 15.
   sram_mem_end #(.DW(DW), .STORE_AW(4)) sram_mem_end_inst (.core_clk(core_clk), .rst(rst),
      .link(link), .write_active(write_active), .read_active(read_active),
      .select_dropped(select_dropped));
   sram_link_monitor sram_link_monitor_inst (.core_clk(core_clk), .rst(rst),
      .k_true(link.k_true), .write_port_select_n(link.write_port_select_n),
      .read_port_select_n(link.read_port_select_n), .q_oe_n(link.q_oe_n));

   // Every comparison funnels through here so the counts stay honest.
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // A wait that runs out is a mismatch and ends the run at once.
   task automatic give_up(input string what);
      check(what, 64'h0, 64'h1);
      tally_and_finish();
   endtask

   // Lanes whose select is high keep the stored bits, the rest take the new beat.
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                            input logic [LN-1:0] sel_n);
      merge = old;
      for (int l = 0; l < LN; l++) begin
         if (!sel_n[l]) merge[l*LW +: LW] = nw[l*LW +: LW];
      end
   endfunction

   // Offers one burst and holds it until taken; valid stays up so bursts can run back to back.
   task automatic push_write(input int a, input logic [MW-1:0] m, input int stall);
      logic            ok;
      logic [63:0]     w;
      logic [4*DW-1:0] dat;
      if (stall > 0) begin
         wr_valid = 1'b0;
         repeat (stall) @(posedge core_clk);
         #5;
      end
      for (int b = 0; b < 4; b++) begin
         w = {$random(seed), $random(seed)};
         dat[b*DW +: DW] = w[DW-1:0];
      end
      wr_data = dat;
      wr_addr = AW'(a);
      wr_lane_sel_n = m;
      wr_valid = 1'b1;
      ok = 1'b0;
      for (int r = 0; r < 200 && ok !== 1'b1; r++) begin
         ok = wr_ready;
         @(posedge core_clk);
         #5;
      end
      if (ok !== 1'b1) give_up("wr_ready");
      for (int b = 0; b < 4; b++) begin
         ref_mem[a][b] = merge(ref_mem[a][b], dat[b*DW +: DW], m[b*LN +: LN]);
      end
   endtask

   // Requests one read burst and queues the four words it must return in order.
   task automatic read_burst(input int a);
      logic ok;
      rd_req_addr = AW'(a);
      rd_req_valid = 1'b1;
      ok = 1'b0;
      for (int r = 0; r < 50 && ok !== 1'b1; r++) begin
         ok = rd_req_ready;
         @(posedge core_clk);
         #5;
      end
      if (ok !== 1'b1) give_up("rd_req_ready");
      for (int b = 0; b < 4; b++) begin
         exp_q.push_back(ref_mem[a][b]);
      end
   endtask

   // Eight quiet cycles cover two slot rings, so no queued burst is left behind.
   task automatic wait_idle(input string name);
      int quiet;
      quiet = 0;
      wr_valid = 1'b0;
      rd_req_valid = 1'b0;
      for (int n = 0; n < 400 && quiet < 8; n++) begin
         @(posedge core_clk);
         #5;
         quiet = (write_active === 1'b0 && read_active === 1'b0 && exp_q.size() == 0
                  && link.write_port_select_n === 1'b1) ? quiet + 1 : 0;
      end
      if (quiet < 8) give_up("idle");
      $display("test %s done, checks %0d failures %0d", name, checks, failures);
   endtask

   task automatic read_all(input string name);
      for (int a = 0; a < 16; a++) begin
         read_burst(a);
      end
      wait_idle(name);
   endtask

   // Read beats are compared on the falling edge, where the controller's flops have settled.
   always @(negedge core_clk) begin
      if (rst === 1'b0 && rd_data_valid === 1'b1) begin
         if (exp_q.size() == 0) check("rd_extra", 64'h1, 64'h0);
         else check("rd_data", 64'(rd_data), 64'(exp_q.pop_front()));
      end
      // The controller keeps its spacing, so the memory must never drop a select.
      if (rst === 1'b0 && select_dropped !== 1'b0) begin
         check("select_dropped", 64'(select_dropped), 64'h0);
      end
   end

   // Main sequence: fill, read back, masked writes, mixed traffic, reset in mid-run.
   initial begin
      seed = 64;
      failures = 0;
      checks = 0;
      rst = 1'b1;
      wr_valid = 1'b0;
      rd_req_valid = 1'b0;
      wr_addr = '0;
      rd_req_addr = '0;
      wr_lane_sel_n = '1;
      wr_data = '0;
      corner = '{16'hFFFF, 16'hEEEE, 16'h7777, 16'h5A5A};
      repeat (2) @(posedge core_clk);
      #5;
      rst = 1'b0;
      repeat (2) @(posedge core_clk);
      #5;
      // The first sixteen bursts write every lane so the whole model is known.
      for (i = 0; i < 40 && wr_ready === 1'b1; i++) begin
         push_write(i % 16, (i < 16) ? '0 : MW'($random(seed)), 0);
      end
      check("fifo_depth", 64'(i >= FIFO_DEPTH), 64'h1);
      check("wr_ready_full", 64'(wr_ready), 64'h0);
      wait_idle("fifo_fill");
      read_all("full_readback");
      // Corner masks first: a fully masked burst, then single lanes, then mixed beats.
      for (i = 0; i < 24; i++) begin
         push_write($random(seed) & 15, (i < 4) ? corner[i] : MW'($random(seed)), i % 3);
      end
      wait_idle("masked_writes");
      read_all("masked_readback");
      // Writes and reads share the address bus in alternate slots.
      // A branch that ends first drops its valid, so its last request is not taken again.
      fork
         begin
            for (int j = 0; j < 8; j++) begin
               push_write(j, MW'($random(seed)), 0);
            end
            wr_valid = 1'b0;
         end
         begin
            for (int j = 8; j < 16; j++) begin
               read_burst(j);
            end
            rd_req_valid = 1'b0;
         end
      join
      wait_idle("mixed_traffic");
      read_all("mixed_readback");
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #5;
      check("q_oe_n_reset", 64'(link.q_oe_n), 64'h1);
      check("wps_reset", 64'(link.write_port_select_n), 64'h1);
      check("wr_ready_reset", 64'(wr_ready), 64'h0);
      rst = 1'b0;
      // Memory contents survive reset, and no stray write slipped in meanwhile.
      read_all("reset_readback");
      tally_and_finish();
   end
endmodule
